// ### pkg/sarr_pkg.sv
// Constants for the status and result readout register bank
package sarr_pkg;

  // Register offsets
  localparam logic [7:0] SARR_ADDR_IRQ_FUNC  = 8'h0a;
  localparam logic [7:0] SARR_ADDR_STATUS    = 8'h20;
  localparam logic [7:0] SARR_ADDR_RP_LOW    = 8'h21;
  localparam logic [7:0] SARR_ADDR_RP_HIGH   = 8'h22;
  localparam logic [7:0] SARR_ADDR_IND_LOW   = 8'h23;
  localparam logic [7:0] SARR_ADDR_IND_HIGH  = 8'h24;

  // Status field positions
  localparam int SARR_BIT_OSC_MISSING = 7;
  localparam int SARR_BIT_READY_N     = 6;
  localparam int SARR_BIT_RP_HIGH_N   = 5;
  localparam int SARR_BIT_RP_HYST     = 4;
  localparam int SARR_BIT_IND_HIGH_N  = 3;
  localparam int SARR_BIT_IND_HYST    = 2;
  localparam int SARR_BIT_POR         = 0;

  // Interrupt function codes that enable the latched flags, and the value that clears them
  localparam logic [5:0] SARR_IRQ_FUNC_RP  = 6'h01;
  localparam logic [5:0] SARR_IRQ_FUNC_IND = 6'h08;
  localparam logic [7:0] SARR_FLAG_CLEAR   = 8'h00;

  // Reset values
  localparam logic [15:0] SARR_RESULT_RST   = 16'h0000;
  localparam logic [7:0]  SARR_BYTE_RST     = 8'h00;
  localparam logic        SARR_HIGH_N_RST   = 1'b1;
  localparam logic        SARR_READY_N_RST  = 1'b1;
  localparam logic        SARR_HYST_RST     = 1'b0;

endpackage

// ### logic/sarr_readout.sv
// Status flags and conversion result register bank
//
// Operation
// R1 - Status bit 7 set when sensor oscillation is not detected, else 0.
// R2 - Oscillation error may also rise when lowest frequency setting is too high.
// R3 - Status bit 6 low when new resistance+inductance result available, else high.
// R4 - Status bit 5 latches low once resistance exceeds upper limit, until cleared; latched here only while interrupt function field is 0x01.
// R5 - Writing 0x00 to register 0x0A clears latched high-threshold flags.
// R6 - Bit 5 reported only when interrupt function field equals 0x01.
// R7 - Bit 4 goes 0 above resistance upper limit, 1 below lower, holds between.
// R8 - Status bit 3 latches low once inductance exceeds upper limit, until cleared; latched here only while interrupt function field is 0x08.
// R9 - Bit 3 reported only when interrupt function field equals 0x08.
// R10 - Bit 2 goes 0 above inductance upper limit, 1 below lower limit.
// R11 - Bit 0 high during reset; configuration writes ignored while high.
// R12 - Host polls bit 0 and writes no configuration until it reads 0.
// R13 - Host reads resistance low byte first, before other result bytes.
// R14 - Resistance result: low byte at 0x21, high byte at 0x22.
// R15 - Inductance result: low byte at 0x23, high byte at 0x24.
// R16 - Inductance result follows the sensor frequency relation from the core.
// R17 - Reading resistance low byte snapshots all result bytes coherently.
`timescale 1ns/1ps
`default_nettype none

module sarr_readout
  import sarr_pkg::*;
#(
  parameter int RES_W = 16
)(
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  // Register access port
  input  wire logic              i_rd_en,
  input  wire logic              i_wr_en,
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata,
  output logic                   o_rvalid,
  // Configuration write forwarded to the config bank
  output logic                   o_cfg_wr_en,
  output logic      [7:0]        o_cfg_addr,
  output logic      [7:0]        o_cfg_wdata,
  // Converter core
  input  wire logic              i_conv_valid,
  input  wire logic [RES_W-1:0]  i_rp_result,
  input  wire logic [RES_W-1:0]  i_ind_result,
  input  wire logic              i_osc_lost,
  input  wire logic [RES_W-1:0]  i_ind_count_ceiling,
  input  wire logic              i_por_busy,
  // Settings from the configuration bank, and the registered status byte
  input  wire logic [5:0]        i_irq_pin_function,
  input  wire logic [RES_W-1:0]  i_rp_upper_limit,
  input  wire logic [RES_W-1:0]  i_rp_lower_limit,
  input  wire logic [RES_W-1:0]  i_ind_upper_limit,
  input  wire logic [RES_W-1:0]  i_ind_lower_limit,
  output logic      [7:0]        o_device_status
);

  //////////////////////////////////////////////////////////////////////////////
  // Signals

  logic             osc_meta_r;
  logic             osc_sync_r;
  logic             freq_low_r;
  logic             osc_missing_r;
  logic             ready_n_r;
  logic             rp_high_n_r;
  logic             rp_hyst_r;
  logic             ind_high_n_r;
  logic             ind_hyst_r;
  logic             por_r;
  logic [RES_W-1:0] rp_live_r;
  logic [RES_W-1:0] ind_live_r;
  logic [RES_W-1:0] rp_snap_r;
  logic [RES_W-1:0] ind_snap_r;
  logic [7:0]       status_nxt;
  logic [7:0]       rdata_nxt;
  logic             rd_rp_low;
  logic             flag_clear;
  logic             rp_above;
  logic             rp_below;
  logic             ind_above;
  logic             ind_below;
  logic             rp_report;
  logic             ind_report;

  assign rd_rp_low  = i_rd_en && (i_addr == SARR_ADDR_RP_LOW);
  assign flag_clear = i_wr_en && !por_r && (i_addr == SARR_ADDR_IRQ_FUNC)
                      && (i_wdata == SARR_FLAG_CLEAR);  // see R5 see R11
  assign rp_above   = i_rp_result > i_rp_upper_limit;
  assign rp_below   = i_rp_result < i_rp_lower_limit;
  assign ind_above  = i_ind_result > i_ind_upper_limit;
  assign ind_below  = i_ind_result < i_ind_lower_limit;
  assign rp_report  = (i_irq_pin_function == SARR_IRQ_FUNC_RP);   // see R6
  assign ind_report = (i_irq_pin_function == SARR_IRQ_FUNC_IND);  // see R9

  //////////////////////////////////////////////////////////////////////////////
  // Oscillation error

  // Analog detector output is asynchronous to the clock
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end
    else
    begin
      osc_meta_r <= i_osc_lost;
      osc_sync_r <= osc_meta_r;
    end
  end

  // Sensor slower than the lowest allowed frequency gives a count above the ceiling
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      freq_low_r <= 1'b0;
    else if (i_conv_valid)
      freq_low_r <= i_ind_result > i_ind_count_ceiling;  // see R2
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      osc_missing_r <= 1'b0;
    else
      osc_missing_r <= osc_sync_r || freq_low_r;  // see R1 see R2
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data ready

  // A new result wins over the read that retires the previous one
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ready_n_r <= SARR_READY_N_RST;
    else if (i_conv_valid)
      ready_n_r <= 1'b0;  // see R3
    else if (rd_rp_low)
      ready_n_r <= 1'b1;  // see R3
  end

  //////////////////////////////////////////////////////////////////////////////
  // Threshold comparators

  // Latched low flags: a crossing in the clear cycle stays latched
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rp_high_n_r <= SARR_HIGH_N_RST;
    else if (i_conv_valid && rp_above && rp_report)
      rp_high_n_r <= 1'b0;  // see R4 see R6
    else if (flag_clear)
      rp_high_n_r <= 1'b1;  // see R5
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ind_high_n_r <= SARR_HIGH_N_RST;
    else if (i_conv_valid && ind_above && ind_report)
      ind_high_n_r <= 1'b0;  // see R8 see R9
    else if (flag_clear)
      ind_high_n_r <= 1'b1;  // see R5
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rp_hyst_r <= SARR_HYST_RST;
    else if (i_conv_valid && rp_above)
      rp_hyst_r <= 1'b0;  // see R7
    else if (i_conv_valid && rp_below)
      rp_hyst_r <= 1'b1;  // see R7
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ind_hyst_r <= SARR_HYST_RST;
    else if (i_conv_valid && ind_above)
      ind_hyst_r <= 1'b0;  // see R10
    else if (i_conv_valid && ind_below)
      ind_hyst_r <= 1'b1;  // see R10
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-on reset and configuration gate

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      por_r <= 1'b0;
    else
      por_r <= i_por_busy;  // see R11
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_cfg_wr_en <= 1'b0;
      o_cfg_addr  <= SARR_BYTE_RST;
      o_cfg_wdata <= SARR_BYTE_RST;
    end
    else
    begin
      o_cfg_wr_en <= i_wr_en && !por_r;  // see R11 see R12
      o_cfg_addr  <= i_addr;
      o_cfg_wdata <= i_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Results and snapshot

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rp_live_r  <= SARR_RESULT_RST;
      ind_live_r <= SARR_RESULT_RST;
    end
    else if (i_conv_valid)
    begin
      rp_live_r  <= i_rp_result;
      ind_live_r <= i_ind_result;  // see R16
    end
  end

  // Later byte reads come from the copy taken at the low byte read
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rp_snap_r  <= SARR_RESULT_RST;
      ind_snap_r <= SARR_RESULT_RST;
    end
    else if (rd_rp_low)
    begin
      rp_snap_r  <= rp_live_r;   // see R17 see R13
      ind_snap_r <= ind_live_r;  // see R17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status and read data

  always_comb
  begin
    status_nxt                       = SARR_BYTE_RST;
    status_nxt[SARR_BIT_OSC_MISSING] = osc_missing_r;                 // see R1
    status_nxt[SARR_BIT_READY_N]     = ready_n_r;                     // see R3
    status_nxt[SARR_BIT_RP_HIGH_N]   = rp_high_n_r || !rp_report;     // see R6
    status_nxt[SARR_BIT_RP_HYST]     = rp_hyst_r;
    status_nxt[SARR_BIT_IND_HIGH_N]  = ind_high_n_r || !ind_report;   // see R9
    status_nxt[SARR_BIT_IND_HYST]    = ind_hyst_r;
    status_nxt[SARR_BIT_POR]         = por_r;                         // see R11
  end

  always_comb
  begin
    case (i_addr)
      SARR_ADDR_STATUS:   rdata_nxt = status_nxt;
      SARR_ADDR_RP_LOW:   rdata_nxt = rp_live_r[7:0];          // see R14
      SARR_ADDR_RP_HIGH:  rdata_nxt = rp_snap_r[15:8];         // see R14
      SARR_ADDR_IND_LOW:  rdata_nxt = ind_snap_r[7:0];         // see R15
      SARR_ADDR_IND_HIGH: rdata_nxt = ind_snap_r[15:8];        // see R15
      default:            rdata_nxt = SARR_BYTE_RST;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata  <= SARR_BYTE_RST;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rdata  <= i_rd_en ? rdata_nxt : SARR_BYTE_RST;
      o_rvalid <= i_rd_en;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_device_status <= SARR_BYTE_RST;
    else
      o_device_status <= status_nxt;
  end

endmodule

`default_nettype wire

// ### tb/sarr_readout_properties.sv
// Port checks for the status and result readout bank
`timescale 1ns/1ps
`default_nettype none
module sarr_readout_properties
  import sarr_pkg::*;
#(
  parameter int RES_W = 16
)(
  input wire logic             i_ref_clk,
  input wire logic             i_arst_n,
  input wire logic             i_rd_en,
  input wire logic             i_wr_en,
  input wire logic [7:0]       i_addr,
  input wire logic             i_conv_valid,
  input wire logic [RES_W-1:0] i_rp_result,
  input wire logic [RES_W-1:0] i_ind_result,
  input wire logic             i_por_busy,
  input wire logic [5:0]       i_irq_pin_function,
  input wire logic [RES_W-1:0] i_rp_upper_limit,
  input wire logic [RES_W-1:0] i_ind_upper_limit,
  input wire logic             o_rvalid,
  input wire logic             o_cfg_wr_en,
  input wire logic [7:0]       o_device_status
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_rvalid; i_rd_en |=> o_rvalid; endproperty
  property p_por_set; i_por_busy |-> ##2 o_device_status[0]; endproperty
  property p_por_clr; !i_por_busy |-> ##2 !o_device_status[0]; endproperty
  // The reset value of the gate flop differs from the pin, so skip the edge after release
  property p_wr_ref; $past(i_arst_n) && i_wr_en && $past(i_por_busy) |=> !o_cfg_wr_en; endproperty
  property p_wr_fwd; $past(i_arst_n) && i_wr_en && !$past(i_por_busy) |=> o_cfg_wr_en; endproperty
  property p_rdy_set; i_conv_valid |-> ##2 !o_device_status[6]; endproperty
  property p_rdy_clr;
    i_rd_en && i_addr == SARR_ADDR_RP_LOW && !i_conv_valid |-> ##2 o_device_status[6];
  endproperty
  property p_rp_latch;
    i_conv_valid && i_irq_pin_function == SARR_IRQ_FUNC_RP && i_rp_result > i_rp_upper_limit
      |-> ##2 !o_device_status[5];
  endproperty
  property p_ind_hyst;
    i_conv_valid && i_ind_result > i_ind_upper_limit |-> ##2 !o_device_status[2];
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  a_por_set: assert property (p_por_set) else $error("reset flag low");
  a_por_clr: assert property (p_por_clr) else $error("reset flag high");
  a_wr_ref: assert property (p_wr_ref) else $error("write passed in reset");
  a_wr_fwd: assert property (p_wr_fwd) else $error("write lost");
  a_rdy_set: assert property (p_rdy_set) else $error("ready not shown");
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared");
  a_rp_latch: assert property (p_rp_latch) else $error("rp flag not set");
  a_ind_hyst: assert property (p_ind_hyst) else $error("ind hyst wrong");
  c_conv: cover property (i_conv_valid);
  c_clear: cover property (i_wr_en && i_addr == SARR_ADDR_IRQ_FUNC);
  c_por: cover property ($fell(i_por_busy));
endmodule
bind sarr_readout sarr_readout_properties #(.RES_W(RES_W)) i_sarr_readout_properties (
  .i_ref_clk          (i_ref_clk),
  .i_arst_n           (i_arst_n),
  .i_rd_en            (i_rd_en),
  .i_wr_en            (i_wr_en),
  .i_addr             (i_addr),
  .i_conv_valid       (i_conv_valid),
  .i_rp_result        (i_rp_result),
  .i_ind_result       (i_ind_result),
  .i_por_busy         (i_por_busy),
  .i_irq_pin_function (i_irq_pin_function),
  .i_rp_upper_limit   (i_rp_upper_limit),
  .i_ind_upper_limit  (i_ind_upper_limit),
  .o_rvalid           (o_rvalid),
  .o_cfg_wr_en        (o_cfg_wr_en),
  .o_device_status    (o_device_status)
);
`default_nettype wire

// ### tb/sarr_host.sv
// Host model on the register port of the readout bank
`timescale 1ns/1ps
`default_nettype none
module sarr_host
  import sarr_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output logic            o_rd_en,
  output logic            o_wr_en,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial {o_rd_en, o_wr_en, o_addr, o_wdata} = '0;
  // Released address and data are inverted so stale values never match
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    #1 o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_ref_clk);
    #1 o_rd_en = 1'b0;
    o_addr = ~a;
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    #1 o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = v;
    @(posedge i_ref_clk);
    #1 o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~v;
  endtask
  task automatic wait_por;
    logic [7:0] s;
    s = 8'h01;
    for (int n = 0; n < 40 && s[0] !== 1'b0; n++) rd(SARR_ADDR_STATUS, s);
  endtask
endmodule
`default_nettype wire

// ### tb/sarr_readout_tb.sv
// Self-checking bench for the status and result readout bank
`timescale 1ns/1ps
`default_nettype none
module sarr_readout_tb;
  import sarr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd, wr, rvalid, cfg_wr;
  logic        conv = 1'b0, osc = 1'b0, por = 1'b1;
  logic [7:0]  addr, wdata, rdata, d;
  logic [7:0]  cfg_addr, cfg_wdata, dev_status;
  logic [15:0] rp = '0, ind = '0, ceil = 16'hff00, hi = 16'h8000, lo = 16'h0100;
  logic [5:0]  irq = SARR_IRQ_FUNC_RP;
  int          fail_count = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  sarr_readout #(.RES_W(16)) i_sarr_readout (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_rd_en(rd), .i_wr_en(wr), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg_wr_en(cfg_wr),
    .o_cfg_addr(cfg_addr), .o_cfg_wdata(cfg_wdata), .i_conv_valid(conv), .i_rp_result(rp),
    .i_ind_result(ind), .i_osc_lost(osc), .i_ind_count_ceiling(ceil), .i_por_busy(por),
    .i_irq_pin_function(irq), .i_rp_upper_limit(hi), .i_rp_lower_limit(lo),
    .i_ind_upper_limit(hi), .i_ind_lower_limit(lo), .o_device_status(dev_status));
  sarr_host i_sarr_host (.i_ref_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_rd_en(rd), .o_wr_en(wr), .o_addr(addr), .o_wdata(wdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic ck(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Status output is loaded at the same edge as the read answer
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_sarr_host.rd(a, d);
    samples_checked++;
    if (d !== e)
    begin
      fail_count++;
      $display("Error reg %h expected %h seen %h", a, e, d);
    end
    if (a == SARR_ADDR_STATUS)
      ck("device_status", e, dev_status);
  endtask
  // Forwarded write stands for the cycle after the write edge
  task automatic wc(input logic [7:0] a, input logic [7:0] v, input logic e);
    i_sarr_host.wr(a, v);
    ck("cfg_wr_en", {7'h00, e}, {7'h00, cfg_wr});
    if (e)
    begin
      ck("cfg_addr", a, cfg_addr);
      ck("cfg_wdata", v, cfg_wdata);
    end
  endtask
  task automatic cv(input logic [15:0] r, input logic [15:0] l);
    @(posedge clk);
    #1 conv = 1'b1;
    rp = r;
    ind = l;
    @(posedge clk);
    #1 conv = 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #20000 fail_count++;
    give_verdict;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rc(SARR_ADDR_STATUS, 8'h69);
    wc(SARR_ADDR_IRQ_FUNC, SARR_FLAG_CLEAR, 1'b0);
    por = 1'b0;
    i_sarr_host.wait_por;
    rc(SARR_ADDR_STATUS, 8'h68);
    for (int a = 8'h21; a < 8'h25; a++) rc(8'(a), SARR_BYTE_RST);
    rc(8'h30, 8'h00);
    cv(16'h9a21, 16'h00f0);
    rc(SARR_ADDR_STATUS, 8'h0c);
    rc(SARR_ADDR_RP_LOW, 8'h21);
    irq = SARR_IRQ_FUNC_IND;
    cv(16'h0050, 16'h9000);
    rc(SARR_ADDR_RP_HIGH, 8'h9a);
    rc(SARR_ADDR_IND_LOW, 8'hf0);
    rc(SARR_ADDR_STATUS, 8'h30);
    wc(SARR_ADDR_IRQ_FUNC, 8'h05, 1'b1);
    rc(SARR_ADDR_STATUS, 8'h30);
    wc(SARR_ADDR_IRQ_FUNC, SARR_FLAG_CLEAR, 1'b1);
    rc(SARR_ADDR_STATUS, 8'h38);
    rc(SARR_ADDR_RP_LOW, 8'h50);
    rc(SARR_ADDR_RP_HIGH, 8'h00);
    rc(SARR_ADDR_IND_HIGH, 8'h90);
    rc(SARR_ADDR_STATUS, 8'h78);
    osc = 1'b1;
    repeat (6) @(posedge clk);
    rc(SARR_ADDR_STATUS, 8'hf8);
    osc = 1'b0;
    repeat (6) @(posedge clk);
    rc(SARR_ADDR_STATUS, 8'h78);
    cv(16'h8200, 16'hff80);
    rc(SARR_ADDR_STATUS, 8'ha0);
    irq = SARR_IRQ_FUNC_RP;
    repeat (2) @(posedge clk);
    rc(SARR_ADDR_STATUS, 8'ha8);
    // Reset in mid-run returns flags and results to their reset values
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 ck("status_in_reset", SARR_BYTE_RST, dev_status);
    rst_n = 1'b1;
    rc(SARR_ADDR_STATUS, 8'h68);
    rc(SARR_ADDR_RP_LOW, SARR_BYTE_RST);
    give_verdict;
  end
endmodule
`default_nettype wire
